// ==== hdl/ifo_pkg.sv ====
package ifo_pkg;

   // apb geometry
   localparam int IFO_ADDR_W = 8;
   localparam int IFO_DATA_W = 32;

   // register byte offsets
   localparam logic [7:0] IFO_OFS_STATUS = 8'h00;
   localparam logic [7:0] IFO_OFS_MASK = 8'h04;
   localparam logic [7:0] IFO_OFS_STATE = 8'h08;

   // status and mask layout (same for both)
   localparam int IFO_EV_W = 2;
   localparam int IFO_EV_LATCH = 0;
   localparam int IFO_EV_TAKE = 1;
   localparam logic [IFO_EV_W-1:0] IFO_EV_RESET = 2'h0;

   // state register layout
   localparam int IFO_SR_PEND = 0;
   localparam int IFO_SR_LATCH = 1;
   localparam int IFO_SR_PIN_LOW = 2;
   localparam int IFO_SR_CNT_LSB = 8;
   localparam int IFO_CNT_W = 8;

   // request pin low time before it counts
   localparam int IFO_T_ILIH_NS = 250;
   localparam int IFO_CLK_NS = 20;
   localparam int IFO_ILIH_CYC = (IFO_T_ILIH_NS + IFO_CLK_NS - 1) / IFO_CLK_NS;

   // port c pullup bit positions
   localparam int IFO_PU_W = 8;
   localparam int IFO_PU_B7 = 7;
   localparam int IFO_PU_B6 = 6;
   localparam int IFO_PU_B5 = 5;
   localparam int IFO_PU_B4 = 4;
   localparam int IFO_PU_B3 = 3;
   localparam int IFO_PU_B2 = 2;
   localparam int IFO_PU_B1 = 1;
   localparam int IFO_PU_B0 = 0;

   // factory option set, fixed at build time
   typedef struct packed {
      logic pullup_opt_bit7;
      logic pullup_opt_bit6;
      logic pullup_opt_bit5;
      logic pullup_opt_bit4;
      logic pullup_opt_bits_2_3;
      logic pullup_opt_bits_0_1;
      logic watchdog_option;
      logic level_sense_option;
   } ifo_opt_t;

   localparam ifo_opt_t IFO_OPT_DEFAULT = 8'h00;

   // what the cpu core tells the front end
   typedef struct packed {
      logic insn_boundary;
      logic i_mask;
   } ifo_cpu_in_t;

endpackage : ifo_pkg

// ==== hdl/ifo_irq_filter.sv ====
`timescale 1ns/1ns
module ifo_irq_filter
   import ifo_pkg::*;
#(
   parameter int MIN_CYC = IFO_ILIH_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic irq_n_pin,
   output logic low_level,
   output logic fall_pulse
);

   localparam int CW = $clog2(MIN_CYC + 1);
   localparam logic [CW-1:0] CNT_MAX = CW'(MIN_CYC);

   logic sync1_reg;
   logic sync2_reg;
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic low_reg;
   logic low_next;
   logic fall_reg;
   logic fall_next;

   // width qualification on the synchronised pin
   always_comb begin
      cnt_next = cnt_reg;
      low_next = low_reg;
      if (sync2_reg) begin
         cnt_next = '0;
         low_next = 1'b0;
      end else begin
         if (cnt_reg != CNT_MAX) begin
            cnt_next = cnt_reg + CW'(1);
         end
         low_next = (cnt_next == CNT_MAX);
      end
      fall_next = low_next & ~low_reg;
   end

   // two-flop synchroniser, then filter state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
         cnt_reg <= '0;
         low_reg <= 1'b0;
         fall_reg <= 1'b0;
      end else begin
         sync1_reg <= irq_n_pin;
         sync2_reg <= sync1_reg;
         cnt_reg <= cnt_next;
         low_reg <= low_next;
         fall_reg <= fall_next;
      end
   end

   assign low_level = low_reg;
   assign fall_pulse = fall_reg;

endmodule : ifo_irq_filter

// ==== hdl/ifo_front.sv ====
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ns
module ifo_front
   import ifo_pkg::*;
#(
   parameter ifo_opt_t OPTIONS = IFO_OPT_DEFAULT,
   parameter int ILIH_CYC = IFO_ILIH_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [IFO_ADDR_W-1:0] paddr,
   input wire logic [IFO_DATA_W-1:0] pwdata,
   output logic [IFO_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic irq_n_pin,
   input wire ifo_cpu_in_t cpu_in,
   output logic irq_seq_start,
   output logic [IFO_PU_W-1:0] pullup_en,
   output logic watchdog_en,
   output logic irq_out
);

   // pullup map built from the fixed options
   function automatic logic [IFO_PU_W-1:0] ifo_pullups(input ifo_opt_t o);
      logic [IFO_PU_W-1:0] p;
      p = '0;
      p[IFO_PU_B7] = o.pullup_opt_bit7;
      p[IFO_PU_B6] = o.pullup_opt_bit6;
      p[IFO_PU_B5] = o.pullup_opt_bit5;
      p[IFO_PU_B4] = o.pullup_opt_bit4;
      p[IFO_PU_B3] = o.pullup_opt_bits_2_3;
      p[IFO_PU_B2] = o.pullup_opt_bits_2_3;
      p[IFO_PU_B1] = o.pullup_opt_bits_0_1;
      p[IFO_PU_B0] = o.pullup_opt_bits_0_1;
      return p;
   endfunction : ifo_pullups

   // true when the address names a mapped register
   function automatic logic ifo_mapped(input logic [IFO_ADDR_W-1:0] a);
      return (a == IFO_OFS_STATUS) || (a == IFO_OFS_MASK) || (a == IFO_OFS_STATE);
   endfunction : ifo_mapped

   // fixed option values, constants of the build
   localparam logic [IFO_PU_W-1:0] PU_CONST = ifo_pullups(OPTIONS);
   localparam logic WD_CONST = OPTIONS.watchdog_option;
   localparam logic LEVEL_MODE = OPTIONS.level_sense_option;

   // qualified request pin
   logic pin_low;
   logic pin_fall;

   ifo_irq_filter #(
      .MIN_CYC(ILIH_CYC)
   ) u_filter (
      .pclk(pclk),
      .presetn(presetn),
      .irq_n_pin(irq_n_pin),
      .low_level(pin_low),
      .fall_pulse(pin_fall)
   );

   // ------- option outputs
   logic [IFO_PU_W-1:0] pullup_reg;
   logic [IFO_PU_W-1:0] pullup_next;
   logic watchdog_reg;
   logic watchdog_next;

   // options never change, registers just hold them
   always_comb begin
      pullup_next = PU_CONST;
      watchdog_next = WD_CONST;
   end

   // reset loads the same constants
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pullup_reg <= PU_CONST;
         watchdog_reg <= WD_CONST;
      end else begin
         pullup_reg <= pullup_next;
         watchdog_reg <= watchdog_next;
      end
   end

   // ------- request latch and sequence start
   logic latch_reg;
   logic latch_next;
   logic take_reg;
   logic take_next;
   logic pending;
   logic [IFO_CNT_W-1:0] take_cnt_reg;
   logic [IFO_CNT_W-1:0] take_cnt_next;

   // request seen by the core at the boundary
   always_comb begin
      pending = latch_reg;
      if (LEVEL_MODE) begin
         pending = latch_reg | pin_low;
      end
   end

   // latch update and boundary decision
   always_comb begin
      latch_next = latch_reg;
      take_next = 1'b0;
      take_cnt_next = take_cnt_reg;
      if (cpu_in.insn_boundary) begin
         if (pending && !cpu_in.i_mask) begin
            take_next = 1'b1;
            latch_next = 1'b0;
            take_cnt_next = take_cnt_reg + IFO_CNT_W'(1);
         end
      end
      // a new edge in the take cycle is kept
      if (pin_fall) begin
         latch_next = 1'b1;
      end
   end

   // latch and sequence start flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_reg <= 1'b0;
         take_reg <= 1'b0;
         take_cnt_reg <= '0;
      end else begin
         latch_reg <= latch_next;
         take_reg <= take_next;
         take_cnt_reg <= take_cnt_next;
      end
   end

   // ------- apb slave
   logic setup;
   logic access;
   logic wr_en;
   logic [IFO_DATA_W-1:0] wdata_ev;
   logic pready_reg;
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic [IFO_DATA_W-1:0] prdata_reg;
   logic [IFO_DATA_W-1:0] prdata_next;

   // phase decode
   always_comb begin
      setup = psel & ~penable;
      access = psel & penable & pready_reg;
      wr_en = access & pwrite;
      wdata_ev = pwdata;
   end

   // ------- event status and mask
   logic [IFO_EV_W-1:0] status_reg;
   logic [IFO_EV_W-1:0] status_next;
   logic [IFO_EV_W-1:0] mask_reg;
   logic [IFO_EV_W-1:0] mask_next;
   logic irq_reg;
   logic irq_next;
   logic [IFO_EV_W-1:0] ev_set;
   logic [IFO_EV_W-1:0] ev_clr;

   // sticky events, write one clears, set wins
   always_comb begin
      ev_set = '0;
      ev_set[IFO_EV_LATCH] = pin_fall;
      ev_set[IFO_EV_TAKE] = take_reg;
      ev_clr = '0;
      if (wr_en && paddr == IFO_OFS_STATUS) begin
         ev_clr = wdata_ev[IFO_EV_W-1:0];
      end
      status_next = (status_reg & ~ev_clr) | ev_set;
      mask_next = mask_reg;
      if (wr_en && paddr == IFO_OFS_MASK) begin
         mask_next = wdata_ev[IFO_EV_W-1:0];
      end
      irq_next = |(status_next & mask_next);
   end

   // status, mask and interrupt flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= IFO_EV_RESET;
         mask_reg <= IFO_EV_RESET;
         irq_reg <= 1'b0;
      end else begin
         status_reg <= status_next;
         mask_reg <= mask_next;
         irq_reg <= irq_next;
      end
   end

   // read data and answer, prepared in setup
   always_comb begin
      pready_next = setup;
      pslverr_next = 1'b0;
      prdata_next = '0;
      if (setup) begin
         pslverr_next = ~ifo_mapped(paddr);
         if (!pwrite) begin
            // options are absent from every register
            unique case (paddr)
               IFO_OFS_STATUS: begin
                  prdata_next[IFO_EV_W-1:0] = status_reg;
               end
               IFO_OFS_MASK: begin
                  prdata_next[IFO_EV_W-1:0] = mask_reg;
               end
               IFO_OFS_STATE: begin
                  prdata_next[IFO_SR_PEND] = pending;
                  prdata_next[IFO_SR_LATCH] = latch_reg;
                  prdata_next[IFO_SR_PIN_LOW] = pin_low;
                  prdata_next[IFO_SR_CNT_LSB +: IFO_CNT_W] = take_cnt_reg;
               end
               default: begin
                  prdata_next = '0;
               end
            endcase
         end
      end else if (access) begin
         pready_next = 1'b0;
      end else begin
         pready_next = pready_reg & psel;
         pslverr_next = pslverr_reg & psel;
         prdata_next = prdata_reg;
      end
   end

   // bus answer flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= '0;
      end else begin
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg <= prdata_next;
      end
   end

   // outputs straight from flops
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq_seq_start = take_reg;
   assign pullup_en = pullup_reg;
   assign watchdog_en = watchdog_reg;
   assign irq_out = irq_reg;

endmodule : ifo_front

// ==== testbench/ifo_front_monitor.sv ====
`timescale 1ns/1ns
module ifo_front_monitor
   import ifo_pkg::*;
#(
   parameter ifo_opt_t OPTIONS = IFO_OPT_DEFAULT,
   parameter int ILIH_CYC = IFO_ILIH_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic irq_n_pin,
   input wire ifo_cpu_in_t cpu_in,
   input wire logic irq_seq_start,
   input wire logic [IFO_PU_W-1:0] pullup_en,
   input wire logic watchdog_en
);
   logic [7:0] low_cnt_reg;
   logic [7:0] low_cnt_next;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // cycles the pin has stayed low, saturating
   always_comb begin
      low_cnt_next = irq_n_pin ? 8'h00 : low_cnt_reg + {7'h00, low_cnt_reg != 8'hff};
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_cnt_reg <= 8'h00;
      end else begin
         low_cnt_reg <= low_cnt_next;
      end
   end
   a_pullup_bit7: assert property (pullup_en[7] == OPTIONS.pullup_opt_bit7)
      else $error("bit7 pullup differs from option");
   a_pullup_singles: assert property (pullup_en[6:4] == OPTIONS[6:4])
      else $error("bit6-4 pullups differ from options");
   a_pullup_pair23: assert property (pullup_en[3:2] == {2{OPTIONS.pullup_opt_bits_2_3}})
      else $error("bit3-2 pullups differ from option");
   a_pullup_pair01: assert property (pullup_en[1:0] == {2{OPTIONS.pullup_opt_bits_0_1}})
      else $error("bit1-0 pullups differ from option");
   a_watchdog_fixed: assert property (watchdog_en == OPTIONS.watchdog_option)
      else $error("watchdog enable differs from option");
   a_start_boundary: assert property (irq_seq_start |-> $past(cpu_in.insn_boundary))
      else $error("sequence start without boundary");
   a_start_unmasked: assert property (irq_seq_start |-> !$past(cpu_in.i_mask))
      else $error("sequence start while masked");
   a_level_repeat: assert property (OPTIONS.level_sense_option && low_cnt_reg > ILIH_CYC + 4
      && cpu_in.insn_boundary && !cpu_in.i_mask |=> irq_seq_start)
      else $error("held low request not taken");
endmodule : ifo_front_monitor

bind ifo_front ifo_front_monitor #(.OPTIONS(OPTIONS), .ILIH_CYC(ILIH_CYC)) u_monitor (.pclk(pclk),
   .presetn(presetn), .irq_n_pin(irq_n_pin), .cpu_in(cpu_in), .irq_seq_start(irq_seq_start),
   .pullup_en(pullup_en), .watchdog_en(watchdog_en));

// ==== testbench/ifo_cpu_model.sv ====
`timescale 1ns/1ns
module ifo_cpu_model
   import ifo_pkg::*;
(
   input wire logic drive_low,
   input wire logic boundary,
   input wire logic mask,
   output logic irq_n_pin,
   output ifo_cpu_in_t cpu_in
);
   // wire-or source, released pin pulled high
   assign irq_n_pin = drive_low ? 1'b0 : 1'b1;
   // core boundary pulse and mask level
   assign cpu_in = {boundary, mask};
endmodule : ifo_cpu_model

// ==== testbench/irq_front_and_mask_options_bench.sv ====
`timescale 1ns/1ns
module irq_front_and_mask_options_bench;
   import ifo_pkg::*;
   localparam int ILIH = 4;
   localparam ifo_opt_t OPT_E = 8'h5a;
   localparam ifo_opt_t OPT_L = 8'ha5;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic drive_low = 1'b0;
   logic bnd = 1'b0;
   logic mask = 1'b1;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic start;
   logic start_l;
   logic [7:0] pu;
   logic [7:0] pu_l;
   logic wd;
   logic wd_l;
   logic irq;
   logic irq_n_pin;
   ifo_cpu_in_t cpu_in;
   logic [32:0] exp_q[$];
   logic [32:0] e;
   logic [1:0] rnd;
   int failures = 0;
   int comparisons = 0;
   int cycles = 0;
   int starts = 0;
   int starts_l = 0;
   always #10 pclk = ~pclk;
   ifo_cpu_model u_cpu (.drive_low(drive_low), .boundary(bnd), .mask(mask), .irq_n_pin(irq_n_pin), .cpu_in(cpu_in));
   ifo_front #(.OPTIONS(OPT_E), .ILIH_CYC(ILIH)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq_n_pin(irq_n_pin), .cpu_in(cpu_in), .irq_seq_start(start), .pullup_en(pu),
      .watchdog_en(wd), .irq_out(irq));
   ifo_front #(.OPTIONS(OPT_L), .ILIH_CYC(ILIH)) dut_level (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
      .irq_n_pin(irq_n_pin), .cpu_in(cpu_in), .irq_seq_start(start_l), .pullup_en(pu_l),
      .watchdog_en(wd_l), .irq_out());
   task automatic check(input string name, input logic [32:0] exp, input logic [32:0] got);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask : check
   task automatic finish_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test
   // one apb transfer, expected {pslverr, prdata} noted first
   task automatic apb(input logic wr, input logic [7:0] adr, input logic [31:0] wdat, input logic [32:0] exp);
      @(posedge pclk);
      exp_q.push_back(exp);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= adr;
      pwdata <= wdat;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // one-cycle instruction boundary from the core
   task automatic boundary();
      @(posedge pclk);
      bnd <= 1'b1;
      @(posedge pclk);
      bnd <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask : boundary
   // response watcher and start counters
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         finish_test();
      end
      if (pready === 1'b1) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1ffffffff;
         check("apb response", e, {pslverr, prdata});
      end
      starts = starts + (start === 1'b1);
      starts_l = starts_l + (start_l === 1'b1);
   end
   initial begin
      rnd = 2'($urandom(45));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      check("pullup bit7", 33'h0, pu[7]);
      check("pullups 6-4", 33'h5, pu[6:4]);
      check("pullups 3-2", 33'h3, pu[3:2]);
      check("pullups 1-0", 33'h0, pu[1:0]);
      check("level pullups", 33'ha3, pu_l);
      check("watchdog", 33'h2, {wd, wd_l});
      $display("test options done");
      rnd = 2'($urandom());
      apb(1'b0, IFO_OFS_STATE, 32'h0, 33'h0);
      apb(1'b1, IFO_OFS_MASK, {30'h0, rnd}, 33'h0);
      apb(1'b0, IFO_OFS_MASK, 32'h0, {31'h0, rnd});
      apb(1'b0, 8'h0c, 32'h0, {1'b1, 32'h0});
      apb(1'b1, IFO_OFS_STATE, 32'hffffffff, 33'h0);
      apb(1'b1, IFO_OFS_MASK, 32'h3, 33'h0);
      $display("test registers done");
      drive_low <= 1'b1;
      repeat (ILIH + 6 + rnd) @(posedge pclk);
      drive_low <= 1'b0;
      boundary();
      check("masked starts", 33'h0, starts);
      apb(1'b0, IFO_OFS_STATE, 32'h0, 33'h3);
      mask <= 1'b0;
      boundary();
      boundary();
      check("edge starts", 33'h1, starts);
      apb(1'b0, IFO_OFS_STATE, 32'h0, 33'h100);
      apb(1'b0, IFO_OFS_STATUS, 32'h0, 33'h3);
      check("irq raised", 33'h1, irq);
      apb(1'b1, IFO_OFS_STATUS, 32'h3, 33'h0);
      apb(1'b1, IFO_OFS_MASK, 32'h0, 33'h0);
      check("irq cleared", 33'h0, irq);
      $display("test edge request done");
      drive_low <= 1'b1;
      repeat (ILIH + 6) @(posedge pclk);
      repeat (3) boundary();
      check("level starts", 33'h4, starts_l);
      check("edge mode starts", 33'h2, starts);
      drive_low <= 1'b0;
      apb(1'b0, IFO_OFS_STATUS, 32'h0, 33'h3);
      check("irq masked", 33'h0, irq);
      $display("test level request done");
      finish_test();
   end
endmodule : irq_front_and_mask_options_bench
